//--- flash_bus_cycle.v
`timescale 1ns/10ps
`include "flash_host_consts.vh"

// one parallel bus cycle: write or read with a timed strobe
module flash_bus_cycle (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        start,
  input  wire        write,
  input  wire [18:0] addr,
  input  wire [7:0]  wdata,
  output wire        done,
  output reg  [7:0]  rdata,
  output reg  [18:0] flash_addr,
  output reg  [7:0]  flash_dq_out,
  output reg         flash_dq_oe,
  input  wire [7:0]  flash_dq_in,
  output reg         flash_ce_n,
  output reg         flash_we_n,
  output reg         flash_oe_n
);
  reg [3:0] count;
  reg       busy;
  reg       fin;

  assign done = fin;

  // strobe counter; data captured on the last cycle of a read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count        <= 4'h0;
      busy         <= 1'b0;
      fin          <= 1'b0;
      rdata        <= 8'h00;
      flash_addr   <= 19'h00000;
      flash_dq_out <= 8'h00;
      flash_dq_oe  <= 1'b0;
      flash_ce_n   <= 1'b1;
      flash_we_n   <= 1'b1;
      flash_oe_n   <= 1'b1;
    end else begin
      fin <= 1'b0;
      if (!busy && start) begin
        busy         <= 1'b1;
        count        <= 4'h0;
        flash_addr   <= addr;
        flash_dq_out <= wdata;
        flash_dq_oe  <= write;
        flash_ce_n   <= 1'b0;
        flash_we_n   <= ~write;
        flash_oe_n   <= write;
      end else if (busy) begin
        if (count == `PULSE_CYC - 1) begin
          busy        <= 1'b0;
          fin         <= 1'b1;
          flash_ce_n  <= 1'b1;
          flash_we_n  <= 1'b1;   // write latched on rising edge
          flash_oe_n  <= 1'b1;
          flash_dq_oe <= 1'b0;
          if (!flash_oe_n)
            rdata <= flash_dq_in;
        end else begin
          count <= count + 4'h1;
        end
      end
    end
  end
endmodule // flash_bus_cycle

//--- flash_dev_model.sv
`timescale 1ns/10ps
// behavioural flash device: commands, lock bits, status
module flash_dev_model (
  input  wire [18:0] flash_addr,
  input  wire [7:0]  flash_dq_out,
  input  wire        flash_ce_n,
  input  wire        flash_we_n,
  input  wire        flash_oe_n,
  input  wire [1:0]  powerdown_lock_input,
  input  wire        vpp_low,
  output wire [7:0]  flash_dq_in,
  output wire        ready_busy_output
);
  reg  [7:0] sr   = 8'h81; // bit 0 reserved, driven 1 on purpose
  reg  [7:0] blk  = 8'h00;
  reg  [7:0] pend = 8'h00;
  reg        mst  = 1'b0; // only ever set
  reg        rds  = 1'b0;
  wire       ovr  = powerdown_lock_input == 2'h2;
  wire [2:0] b    = flash_addr[18:16];
  // a write ends at whichever of strobe or select rises first
  wire       wr_strobe_n = flash_we_n | flash_ce_n;
  // status or array data when read, inverted status when released
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? (rds ? sr : 8'h3c) : ~sr;
  assign ready_busy_output = sr[7];
  // low level clears status and restarts in array read
  always @(powerdown_lock_input) if (powerdown_lock_input == 2'h0) begin
    sr = 8'h81;
    rds = 1'b0;
    pend = 8'h00;
  end
  // internal algorithm: busy, then flags
  task run(input integer eb, input bad, output ok);
    begin
      sr[7] = 1'b0;
      #300;
      if (vpp_low) sr = sr | 8'h08 | (8'h01 << eb);
      else if (bad) sr = sr | 8'h02 | (8'h01 << eb);
      ok = !vpp_low && !bad;
      sr[7] = 1'b1;
    end
  endtask
  // command interface, latched when the write strobe or select rises
  always @(posedge wr_strobe_n) if (powerdown_lock_input != 2'h0) begin : cmd
    reg ok;
    rds = 1'b1;
    case (pend)
      8'h20: begin
        pend = 8'h00;
        if (flash_dq_out == 8'hd0) run(5, blk[b] && !ovr, ok);
        else sr = sr | 8'h30;
      end
      8'h40: begin
        pend = 8'h00;
        run(4, blk[b] && !ovr, ok);
      end
      8'h60: begin
        pend = 8'h00;
        case (flash_dq_out)
          8'hd0: begin run(5, mst && !ovr, ok); if (ok) blk = 8'h00; end
          8'h01: begin run(4, mst && !ovr, ok); if (ok) blk[b] = 1'b1; end
          8'hf1: begin run(4, !ovr, ok); if (ok) mst = 1'b1; end
          default: sr = sr | 8'h30;
        endcase
      end
      default: begin
        pend = (flash_dq_out == 8'h20 || flash_dq_out == 8'h40 || flash_dq_out == 8'h60) ?
               flash_dq_out : 8'h00;
        if (flash_dq_out == 8'h50) sr = sr & 8'hc5;
        if (flash_dq_out == 8'hff) rds = 1'b0;
      end
    endcase
  end
endmodule // flash_dev_model

//--- flash_host_consts.vh
`ifndef FLASH_HOST_CONSTS_VH
`define FLASH_HOST_CONSTS_VH

// apb register offsets (controller's own map)
`define REG_CTRL          8'h00
`define REG_ADDR          8'h04
`define REG_DATA          8'h08
`define REG_STAT          8'h0c
`define REG_RESULT        8'h10
`define REG_PD            8'h14

// ctrl register fields
`define CTRL_GO_BIT       8
`define CTRL_OP_LSB       0
`define CTRL_OP_MSB       2

// operation codes written to ctrl
`define OP_ERASE          3'h0
`define OP_WRITE          3'h1
`define OP_SET_BLOCK      3'h2
`define OP_SET_MASTER     3'h3
`define OP_CLEAR_LOCKS    3'h4
`define OP_READ_ARRAY     3'h5
`define OP_CLEAR_STATUS   3'h6
`define OP_READ_STATUS    3'h7

// flash command codes
`define CMD_ERASE_SETUP   8'h20
`define CMD_CONFIRM       8'hd0
`define CMD_WRITE_SETUP   8'h40
`define CMD_LOCK_SETUP    8'h60
`define CMD_BLOCK_LOCK    8'h01
`define CMD_MASTER_LOCK   8'hf1
`define CMD_READ_ARRAY    8'hff
`define CMD_CLEAR_STATUS  8'h50
`define CMD_READ_STATUS   8'h70

// status register bit positions
`define SR_READY          7
`define SR_ERASE_PAUSED   6
`define SR_ERASE_ERR      5
`define SR_PROG_ERR       4
`define SR_SUPPLY_LOW     3
`define SR_PROG_PAUSED    2
`define SR_PROTECT        1
`define SR_VALID_MASK     8'hfe
`define SR_RESET          8'h80

// bus timing
`define T_PULSE_NS        50
`define PCLK_NS           10
`define PULSE_CYC         ((`T_PULSE_NS + `PCLK_NS - 1) / `PCLK_NS)

// powerdown/lock drive levels
`define PD_LOW            2'h0
`define PD_NORMAL         2'h1
`define PD_OVERRIDE       2'h2
`define PD_UNSUPPORTED    2'h3

`endif

//--- flash_lock_host.v
// Contract
// - clear locks is 60h then d0h at any address
// - host flags (relock_needed) a clear aborted by supply loss or powerdown; it does not repeat it
// - host masks reserved status bit 0 when polling
// - host ignores bits 6 to 0 while bit 7 is zero
// - erase is 20h then d0h in block; write is 40h then data
// - lock set is 60h then 01h for block or f1h for master
// - error bits sticky until clear-status or power-down; ffh returns to array read
`timescale 1ns/10ps
`include "flash_host_consts.vh"

module flash_lock_host (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire [18:0] flash_addr,
  output wire [7:0]  flash_dq_out,
  output wire        flash_dq_oe,
  input  wire [7:0]  flash_dq_in,
  output wire        flash_ce_n,
  output wire        flash_we_n,
  output wire        flash_oe_n,
  output reg  [1:0]  powerdown_lock_input,
  input  wire        ready_busy_output
);
  // one-hot sequencer states
  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_CMD1  = 7'h02;
  localparam [6:0] S_CMD2  = 7'h04;
  localparam [6:0] S_POLL  = 7'h08;
  localparam [6:0] S_WAIT  = 7'h10;
  localparam [6:0] S_RDARR = 7'h20;
  localparam [6:0] S_FIN   = 7'h40;

  reg  [6:0]  state;
  reg  [2:0]  op;
  reg  [18:0] tgt_addr;
  reg  [7:0]  tgt_data;
  reg  [7:0]  engine_status_reg;
  reg  [7:0]  result;
  reg         relock_needed;
  reg         busy;
  reg         cyc_start;
  reg         cyc_write;
  reg  [7:0]  cyc_wdata;
  wire        cyc_done;
  wire [7:0]  cyc_rdata;
  wire        wr_acc;
  wire        go;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_acc  = psel & penable & pwrite;
  assign go      = wr_acc && (paddr == `REG_CTRL) && pwdata[`CTRL_GO_BIT] && !busy;

  // unpack status fields for readback
  wire engine_ready_flag          = engine_status_reg[`SR_READY];
  wire erase_paused_flag          = engine_status_reg[`SR_ERASE_PAUSED];
  wire erase_unlock_error_flag    = engine_status_reg[`SR_ERASE_ERR];
  wire program_lockset_error_flag = engine_status_reg[`SR_PROG_ERR];
  wire program_supply_low_flag    = engine_status_reg[`SR_SUPPLY_LOW];
  wire program_paused_flag        = engine_status_reg[`SR_PROG_PAUSED];
  wire protect_abort_flag         = engine_status_reg[`SR_PROTECT];
  wire seq_error = erase_unlock_error_flag & program_lockset_error_flag;

  // apb read mux
  always @* begin
    case (paddr)
      `REG_CTRL:   prdata = {23'h000000, busy, 5'h00, op};
      `REG_ADDR:   prdata = {13'h0000, tgt_addr};
      `REG_DATA:   prdata = {24'h000000, tgt_data};
      `REG_STAT:   prdata = {21'h00000, relock_needed, seq_error, ready_busy_output,
                             engine_status_reg};
      `REG_RESULT: prdata = {24'h000000, result};
      `REG_PD:     prdata = {30'h00000000, powerdown_lock_input};
      default:     prdata = 32'h00000000;
    endcase
  end

  // first command byte of each operation
  function [7:0] first_cmd;
    input [2:0] o;
    begin
      case (o)
        `OP_ERASE:        first_cmd = `CMD_ERASE_SETUP;
        `OP_WRITE:        first_cmd = `CMD_WRITE_SETUP;
        `OP_SET_BLOCK:    first_cmd = `CMD_LOCK_SETUP;
        `OP_SET_MASTER:   first_cmd = `CMD_LOCK_SETUP;
        `OP_CLEAR_LOCKS:  first_cmd = `CMD_LOCK_SETUP;
        `OP_CLEAR_STATUS: first_cmd = `CMD_CLEAR_STATUS;
        `OP_READ_STATUS:  first_cmd = `CMD_READ_STATUS;
        default:          first_cmd = `CMD_READ_ARRAY;
      endcase
    end
  endfunction

  // second command byte, or data for a byte write
  function [7:0] second_cmd;
    input [2:0] o;
    input [7:0] d;
    begin
      case (o)
        `OP_ERASE:       second_cmd = `CMD_CONFIRM;
        `OP_WRITE:       second_cmd = d;
        `OP_SET_BLOCK:   second_cmd = `CMD_BLOCK_LOCK;
        `OP_SET_MASTER:  second_cmd = `CMD_MASTER_LOCK;
        default:         second_cmd = `CMD_CONFIRM;
      endcase
    end
  endfunction

  wire two_cycle = (op == `OP_ERASE) || (op == `OP_WRITE) || (op == `OP_SET_BLOCK) ||
                   (op == `OP_SET_MASTER) || (op == `OP_CLEAR_LOCKS);

  // register writes and command sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                <= S_IDLE;
      op                   <= `OP_READ_ARRAY;
      tgt_addr             <= 19'h00000;
      tgt_data             <= 8'h00;
      engine_status_reg    <= `SR_RESET;
      result               <= 8'h00;
      relock_needed        <= 1'b0;
      busy                 <= 1'b0;
      cyc_start            <= 1'b0;
      cyc_write            <= 1'b0;
      cyc_wdata            <= 8'h00;
      powerdown_lock_input <= `PD_LOW;
    end else begin
      cyc_start <= 1'b0;
      if (wr_acc && paddr == `REG_ADDR && !busy)
        tgt_addr <= pwdata[18:0];
      if (wr_acc && paddr == `REG_DATA && !busy)
        tgt_data <= pwdata[7:0];
      // level kept among three legal values; mid level unsupported
      if (wr_acc && paddr == `REG_PD && pwdata[1:0] != `PD_UNSUPPORTED)
        powerdown_lock_input <= pwdata[1:0];
      if (powerdown_lock_input == `PD_LOW)
        engine_status_reg <= `SR_RESET;
      case (state)
        S_IDLE: begin
          if (go) begin
            op        <= pwdata[`CTRL_OP_MSB:`CTRL_OP_LSB];
            busy      <= 1'b1;
            cyc_start <= 1'b1;
            cyc_write <= 1'b1;
            cyc_wdata <= first_cmd(pwdata[`CTRL_OP_MSB:`CTRL_OP_LSB]);
            state     <= S_CMD1;
          end
        end
        S_CMD1: begin
          if (cyc_done) begin
            cyc_start <= 1'b1;
            if (two_cycle) begin
              cyc_write <= 1'b1;
              cyc_wdata <= second_cmd(op, tgt_data);
              state     <= S_CMD2;
            end else begin
              // single commands: read status back, or array data for read array
              cyc_write <= 1'b0;
              state     <= S_POLL;
            end
          end
        end
        S_CMD2: begin
          if (cyc_done) begin
            state <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (powerdown_lock_input == `PD_LOW) begin
            // device held in power-down never answers: give up, flag a redo if clearing locks
            if (op == `OP_CLEAR_LOCKS)
              relock_needed <= 1'b1;
            state <= S_FIN;
          end else begin
            // device reads status after the pair, poll bit 7
            cyc_start <= 1'b1;
            cyc_write <= 1'b0;
            state     <= S_POLL;
          end
        end
        S_POLL: begin
          if (cyc_done) begin
            if (op == `OP_READ_ARRAY) begin
              // array data carries no ready bit: take it as it comes
              result <= cyc_rdata;
              state  <= S_FIN;
            end else if (cyc_rdata[`SR_READY]) begin
              // mask reserved bit, use the rest only when ready
              engine_status_reg <= cyc_rdata & `SR_VALID_MASK;
              result            <= cyc_rdata & `SR_VALID_MASK;
              // a clear cut short by low supply leaves locks undetermined
              if (op == `OP_CLEAR_LOCKS)
                relock_needed <= cyc_rdata[`SR_SUPPLY_LOW];
              cyc_start <= 1'b1;
              cyc_write <= 1'b1;
              cyc_wdata <= `CMD_READ_ARRAY;
              state     <= S_RDARR;
            end else begin
              engine_status_reg[`SR_READY] <= 1'b0;
              state <= S_WAIT;
            end
          end
        end
        S_RDARR: begin
          if (cyc_done)
            state <= S_FIN;
        end
        S_FIN: begin
          busy  <= 1'b0;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // read array op is a plain array read at target
  flash_bus_cycle u_cycle (
    .pclk         (pclk),
    .presetn      (presetn),
    .start        (cyc_start),
    .write        (cyc_write),
    .addr         (tgt_addr),
    .wdata        (cyc_wdata),
    .done         (cyc_done),
    .rdata        (cyc_rdata),
    .flash_addr   (flash_addr),
    .flash_dq_out (flash_dq_out),
    .flash_dq_oe  (flash_dq_oe),
    .flash_dq_in  (flash_dq_in),
    .flash_ce_n   (flash_ce_n),
    .flash_we_n   (flash_we_n),
    .flash_oe_n   (flash_oe_n)
  );
endmodule // flash_lock_host

//--- flash_lock_host_bench.sv
`timescale 1ns/10ps
`include "flash_host_consts.vh"
module flash_lock_host_bench;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0;
  reg         vpp_low = 1'b0;
  wire [31:0] prdata;
  wire        pready, pslverr, dq_oe, ce_n, we_n, oe_n, rb;
  wire [18:0] faddr;
  wire [7:0]  dq_out, dq_in;
  wire [1:0]  pd;
  integer     fail_count = 0, checked = 0, i;
  reg  [31:0] seed = 32'h0000003c, rd;
  reg  [7:0]  blk = 8'h00, ex;
  reg         mst = 1'b0, vl, rl = 1'b0;
  reg  [18:0] a;
  reg  [2:0]  op;
  reg  [1:0]  lv;
  always #5 pclk = ~pclk;
  flash_lock_host u_flash_lock_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_addr(faddr), .flash_dq_out(dq_out),
    .flash_dq_oe(dq_oe), .flash_dq_in(dq_in), .flash_ce_n(ce_n), .flash_we_n(we_n),
    .flash_oe_n(oe_n), .powerdown_lock_input(pd), .ready_busy_output(rb));
  flash_dev_model u_flash_dev_model (.flash_addr(faddr), .flash_dq_out(dq_out),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .powerdown_lock_input(pd),
    .vpp_low(vpp_low), .flash_dq_in(dq_in), .ready_busy_output(rb));
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin t = s ^ (s << 13); t = t ^ (t >> 17); xs = t ^ (t << 5); end
  endfunction
  // status the device should report after an operation
  function [7:0] expect_sr(input [2:0] o, input [1:0] l, input b, input m, input v);
    reg       prot;
    reg [7:0] eb;
    begin
      eb = (o == `OP_ERASE || o == `OP_CLEAR_LOCKS) ? 8'h20 : 8'h10;
      prot = (l != `PD_OVERRIDE) && (o == `OP_SET_MASTER || (o <= `OP_WRITE ? b : m));
      expect_sr = v ? (8'h88 | eb) : (prot ? (8'h82 | eb) : 8'h80);
    end
  endfunction
  // one apb transfer; waits for pready
  task apb(input w, input [7:0] ad, input [31:0] d);
    begin
      psel <= 1'b1; pwrite <= w; paddr <= ad; pwdata <= d;
      @(posedge pclk); penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  // start an operation and poll busy until it ends
  task op_run(input [2:0] o, input [18:0] ad, input [7:0] d);
    integer n;
    begin
      n = 0;
      apb(1, `REG_ADDR, {13'h0, ad});
      apb(1, `REG_DATA, {24'h0, d});
      apb(1, `REG_CTRL, 32'h100 | o);
      rd = 32'h100;
      while (rd[8] !== 1'b0 && n < 500) begin apb(0, `REG_CTRL, 32'h0); n = n + 1; end
      if (n >= 500) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: busy never cleared", $time);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // random operations, levels and supply faults; first two fixed
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 8'h18, 32'h0); chk(rd, 32'h0);
    apb(0, `REG_STAT, 32'h0); chk(rd[7:0], 8'h80);
    for (i = 0; i < 24; i = i + 1) begin
      seed = xs(seed);
      a = seed[18:0];
      op = seed[21:19] % 5;
      lv = seed[22] ? `PD_OVERRIDE : `PD_NORMAL;
      vl = (seed[26:24] == 3'h0) && i > 1;
      if (i < 2) begin op = (i == 0) ? `OP_SET_MASTER : `OP_CLEAR_LOCKS; lv = `PD_NORMAL; end
      vpp_low <= vl;
      apb(1, `REG_PD, {30'h0, lv});
      ex = expect_sr(op, lv, blk[a[18:16]], mst, vl);
      op_run(op, a, seed[31:24]);
      if (op == `OP_CLEAR_LOCKS) rl = vl;
      apb(0, `REG_STAT, 32'h0); chk(rd[10:0], {rl, 2'b01, ex});
      apb(0, `REG_RESULT, 32'h0); chk(rd[7:0], ex);
      if (ex == 8'h80 && op == `OP_SET_BLOCK) blk[a[18:16]] = 1'b1;
      if (ex == 8'h80 && op == `OP_CLEAR_LOCKS) blk = 8'h00;
      if (ex == 8'h80 && op == `OP_SET_MASTER) mst = 1'b1;
      if (ex != 8'h80) begin
        op_run(`OP_CLEAR_STATUS, a, 8'h00);
        apb(0, `REG_STAT, 32'h0); chk(rd[7:0], 8'h80);
      end
      // a clear cut short by low supply is repeated once supply is back
      if (vl && op == `OP_CLEAR_LOCKS) begin
        vpp_low <= 1'b0;
        ex = expect_sr(op, lv, 1'b0, mst, 1'b0);
        op_run(op, a, 8'h00);
        rl = 1'b0;
        apb(0, `REG_STAT, 32'h0); chk(rd[10:0], {rl, 2'b01, ex});
        if (ex == 8'h80) blk = 8'h00;
        op_run(`OP_CLEAR_STATUS, a, 8'h00);
      end
    end
    // status and array reads, then an error left standing into power-down
    op_run(`OP_READ_STATUS, a, 8'h00);
    apb(0, `REG_RESULT, 32'h0); chk(rd[7:0], 8'h80);
    op_run(`OP_READ_ARRAY, a, 8'h00);
    apb(0, `REG_RESULT, 32'h0); chk(rd[7:0], 8'h3c);
    vpp_low <= 1'b1;
    ex = expect_sr(`OP_ERASE, lv, blk[a[18:16]], mst, 1'b1);
    op_run(`OP_ERASE, a, 8'h00);
    apb(0, `REG_STAT, 32'h0); chk(rd[7:0], ex);
    apb(1, `REG_PD, 32'h0);
    apb(0, `REG_STAT, 32'h0); chk(rd[7:0], 8'h80);
    summarize;
  end
  initial begin
    #400000;
    fail_count = fail_count + 1;
    summarize;
  end
endmodule // flash_lock_host_bench

//--- flash_lock_host_chk.sv
`timescale 1ns/10ps
`include "flash_host_consts.vh"
// protocol checks on the host's flash and apb ports
module flash_lock_host_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [18:0] flash_addr,
  input wire [7:0]  flash_dq_out,
  input wire        flash_dq_oe,
  input wire        flash_ce_n,
  input wire        flash_we_n,
  input wire        flash_oe_n,
  input wire [1:0]  powerdown_lock_input
);
  wire [1:0] pd_req = pwdata[1:0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // strobe shapes and level write
  sequence we_pulse; !flash_we_n [*5] ##1 flash_we_n; endsequence
  sequence pd_wr; psel && penable && pwrite && paddr == `REG_PD && pd_req != 2'h3; endsequence
  a_we_width: assert property ($fell(flash_we_n) |-> we_pulse)
    else $error("write strobe width");
  a_oe_width: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*5])
    else $error("read strobe width");
  a_we_select: assert property (!flash_we_n |-> !flash_ce_n && flash_dq_oe)
    else $error("write without select or drive");
  a_no_overlap: assert property (!(!flash_we_n && !flash_oe_n))
    else $error("read and write strobes overlap");
  a_read_release: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("data driven during read");
  a_cmd_stable: assert property (!flash_we_n && !$fell(flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_out))
    else $error("command moved in strobe");
  a_pd_legal: assert property (powerdown_lock_input != 2'h3)
    else $error("illegal level");
  a_pd_write: assert property (pd_wr |=> powerdown_lock_input == $past(pd_req))
    else $error("level write lost");
endmodule // flash_lock_host_chk
bind flash_lock_host flash_lock_host_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_ce_n, .flash_we_n,
  .flash_oe_n, .powerdown_lock_input);
